/* File: etwb_pkg.sv */
// Package for the external table write bus block.
// Holds register offsets, field layouts, reset values, mode codes and timing.
package etwb_pkg;
    // ------------------------------------------------------------
    // Register map (byte addresses on the AXI4-Lite slave)
    // ------------------------------------------------------------
    localparam logic [7:0] ETWB_MEMCTL_OFF = 8'h00;  // memory_control_reg
    localparam logic [7:0] ETWB_LATCH_OFF = 8'h04;   // table_latch
    localparam logic [7:0] ETWB_PTR_OFF = 8'h08;     // table_pointer
    localparam logic [7:0] ETWB_CMD_OFF = 8'h0C;     // command / status
    localparam logic [7:0] ETWB_RDATA_OFF = 8'h10;   // last 16-bit bus read word
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int ETWB_WAIT_LSB = 0;    // memory_control_reg wait field [1:0]
    localparam int ETWB_MD_LSB = 4;      // write_mode_field [5:4]
    localparam int ETWB_BUS8_BIT = 7;    // 1 = 8-bit external bus
    localparam int ETWB_CMD_WR_BIT = 0;  // write 1: start table_write_op
    localparam int ETWB_CMD_RD_BIT = 1;  // write 1: start table_read_op
    localparam int ETWB_CMD_FETCH_BIT = 2; // write 1: start instruction fetch
    localparam int ETWB_BUSY_BIT = 8;    // read: cycle in progress
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [1:0] ETWB_WAIT_RST = 2'h3;  // Slowest memory at power-up
    localparam logic [1:0] ETWB_MD_RST = 2'h0;
    localparam logic [20:0] ETWB_PTR_RST = 21'h000000;
    // ------------------------------------------------------------
    // Timing: one instruction cycle is four quarter phases
    // ------------------------------------------------------------
    localparam int ETWB_QUARTERS = 4;
    localparam int ETWB_BASE_TCY = 2;    // Table write/read length without waits
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ETWB_MD_BYTE_WRITE = 2'b00,
        ETWB_MD_WORD_WRITE = 2'b01,
        ETWB_MD_BYTE_SELECT = 2'b10,
        ETWB_MD_RSVD = 2'b11
    } etwb_md_t;
    typedef enum logic [1:0] {
        ETWB_OP_NONE = 2'b00,
        ETWB_OP_WRITE = 2'b01,
        ETWB_OP_READ = 2'b10,
        ETWB_OP_FETCH = 2'b11
    } etwb_op_t;
endpackage

/* File: etwb_phase_if.sv */
// Interface carrying cycle-sequencer signals between the phase timer and the core.
// Assumes one clock shared by both ends.
`timescale 1ns/1ns
interface etwb_phase_if;
    logic start;        // One-cycle pulse: begin a bus cycle
    logic [1:0] waits;  // Extra instruction cycles to insert
    logic active;       // Bus cycle in progress
    logic data_phase;   // Final instruction cycle (data portion)
    logic q4;           // Fourth quarter of the final cycle
    logic done;         // One-cycle pulse: cycle complete
    modport ctrl (output start, output waits, input active, input data_phase,
        input q4, input done);
    modport timer (input start, input waits, output active, output data_phase,
        output q4, output done);
endinterface

/* File: etwb_phase_timer.sv */
// Quarter-phase sequencer for one external bus cycle.
// Assumes the core pulses start only while active is low.
`timescale 1ns/1ns
module etwb_phase_timer
    import etwb_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic srst_i,
    // Sequencer link
    etwb_phase_if.timer ph
);
    logic active_reg;
    logic [1:0] quarter_reg;
    logic [2:0] tcy_reg;   // Instruction cycles remaining after this one
    logic [1:0] wait_reg;  // Wait cycles still to insert in Q4
    logic last_q;
    logic wait_left;

    // --------------------------------------------------------
    // Phase decode
    // --------------------------------------------------------
    assign last_q = (quarter_reg == 2'(ETWB_QUARTERS - 1));
    assign wait_left = (wait_reg != 2'h0);
    assign ph.active = active_reg;
    assign ph.data_phase = active_reg && (tcy_reg == 3'h0);
    assign ph.q4 = ph.data_phase && last_q;
    assign ph.done = ph.q4 && !wait_left;

    // Quarter and cycle counting; waits stretch Q4 of the final cycle
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            active_reg <= 1'b0;
            quarter_reg <= 2'h0;
            tcy_reg <= 3'h0;
            wait_reg <= 2'h0;
        end else if (ph.start) begin
            active_reg <= 1'b1;
            quarter_reg <= 2'h0;
            tcy_reg <= 3'(ETWB_BASE_TCY - 1);
            wait_reg <= ph.waits;
        end else if (active_reg) begin
            if (ph.q4 && wait_left) begin
                quarter_reg <= 2'h0; // Whole extra Tcy held in final cycle
                wait_reg <= wait_reg - 2'h1;
            end else if (ph.done) begin
                active_reg <= 1'b0;
                quarter_reg <= 2'h0;
            end else begin
                quarter_reg <= quarter_reg + 2'h1;
                if (last_q) begin
                    tcy_reg <= tcy_reg - 3'h1;
                end
            end
        end
    end
endmodule

/* File: etwb_core.sv */
// External table read/write bus engine with AXI4-Lite register access.
// Assumes a single 20 MHz clock and an external word- or byte-wide memory.
//
// Local design decisions: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ns

// Contract
// - Byte write mode drives latch byte on both bus halves.
// - Byte write mode strobes high or low write by pointer bit 0.
// - Word mode even write holds byte, floats bus, no strobe.
// - Word mode odd write drives latch high, held byte low.
// - Word mode uses only the high write strobe.
// - Word mode odd write asserts both byte selects; byte address follows pointer.
// - Byte select mode drives both halves, strobes only high write.
// - Byte select mode marks byte by address line and byte selects.
// - Wait cycles only on table reads and writes, never fetches.
// - Two-bit wait field adds zero to three Tcy, inserted in Q4.
// - Wait field resets to three extra cycles.
// - No long writes; configuration memory not programmable here.
// - Table write takes two Tcy, data written in the final one.
// - Eight-bit bus writes byte directly with the low strobe.
// - Table reads pick bus byte by pointer bit 0, or direct.
module etwb_core
    import etwb_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic srst_i,
    // AXI4-Lite write address and data
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // External multiplexed bus
    input wire logic [15:0] ad_i,
    output logic [15:0] ad_o,
    output logic [15:0] ad_oe_n_o,
    output logic [20:0] addr_o,
    output logic write_high_strobe_n_o,
    output logic write_low_strobe_n_o,
    output logic upper_byte_select_n_o,
    output logic lower_byte_select_n_o,
    output logic byte_address_line_o,
    output logic read_strobe_n_o
);
    etwb_phase_if ph();

    etwb_phase_timer u_timer (
        .core_clk_i(core_clk_i),
        .srst_i(srst_i),
        .ph(ph)
    );

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [1:0] wait_reg;
    etwb_md_t md_reg;
    logic bus8_reg;

    logic [7:0] table_latch_reg;
    logic [20:0] table_pointer_reg;
    logic [7:0] hold_reg;
    logic [15:0] rword_reg;
    etwb_op_t op_reg;
    logic ptr0_reg;

    logic aw_full_reg, w_full_reg;
    logic [7:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic bvalid_reg, bslverr_reg;
    logic rvalid_reg, rslverr_reg;
    logic [31:0] rdata_reg;

    // Bus input synchroniser stages
    logic [15:0] ad_sync1_reg, ad_sync2_reg, ad_sync3_reg;

    // ------------------------------------------------------------
    // AXI write decode
    // ------------------------------------------------------------
    wire wr_fire = aw_full_reg && w_full_reg && !bvalid_reg;
    wire sel_memctl = (aw_addr_reg == ETWB_MEMCTL_OFF);
    wire sel_latch = (aw_addr_reg == ETWB_LATCH_OFF);
    wire sel_ptr = (aw_addr_reg == ETWB_PTR_OFF);
    wire sel_cmd = (aw_addr_reg == ETWB_CMD_OFF);
    wire sel_rdat = (aw_addr_reg == ETWB_RDATA_OFF);
    wire wr_mapped = sel_memctl || sel_latch || sel_ptr || sel_cmd || sel_rdat;
    wire busy = ph.active;

    // Latch and pointer writes are refused while a cycle uses them
    wire wr_ok = wr_fire && wr_mapped && !(busy && (sel_latch || sel_ptr || sel_cmd));
    wire cmd_wr = wr_ok && sel_cmd && w_strb_reg[0] && w_data_reg[ETWB_CMD_WR_BIT];
    wire cmd_rd = wr_ok && sel_cmd && w_strb_reg[0] && w_data_reg[ETWB_CMD_RD_BIT];
    wire cmd_fe = wr_ok && sel_cmd && w_strb_reg[0] && w_data_reg[ETWB_CMD_FETCH_BIT];
    wire [1:0] waits_sel = cmd_fe ? 2'h0 : wait_reg;

    assign s_axi_awready = !aw_full_reg;
    assign s_axi_wready = !w_full_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bslverr_reg ? 2'b10 : 2'b00;

    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rslverr_reg ? 2'b10 : 2'b00;

    // Address and data holding, taken in either order
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 32'h00000000;
            w_strb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bslverr_reg <= 1'b0;
        end else begin
            if (s_axi_awvalid && !aw_full_reg) begin
                aw_full_reg <= 1'b1;
                aw_addr_reg <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (s_axi_wvalid && !w_full_reg) begin
                w_full_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_full_reg <= 1'b0;
                w_full_reg <= 1'b0;
                bvalid_reg <= 1'b1;
                bslverr_reg <= !wr_ok;
            end else if (s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // AXI read decode
    // ------------------------------------------------------------
    wire [7:0] ra = {s_axi_araddr[7:2], 2'b00};
    wire rd_memctl = (ra == ETWB_MEMCTL_OFF);
    wire rd_mapped = rd_memctl || (ra == ETWB_LATCH_OFF) || (ra == ETWB_PTR_OFF)
        || (ra == ETWB_CMD_OFF) || (ra == ETWB_RDATA_OFF);

    wire [31:0] memctl_word = {24'h000000, bus8_reg, 1'b0, md_reg, 2'b00, wait_reg};
    wire [31:0] rd_word =
        rd_memctl ? memctl_word :
        (ra == ETWB_LATCH_OFF) ? {24'h000000, table_latch_reg} :
        (ra == ETWB_PTR_OFF) ? {11'h000, table_pointer_reg} :
        (ra == ETWB_CMD_OFF) ? {23'h000000, busy, 8'h00} :
        (ra == ETWB_RDATA_OFF) ? {16'h0000, rword_reg} : 32'h00000000;

    // Read answer one cycle after address is taken
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            rvalid_reg <= 1'b0;
            rslverr_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
        end else if (s_axi_arvalid && !rvalid_reg) begin
            rvalid_reg <= 1'b1;
            rslverr_reg <= !rd_mapped;
            rdata_reg <= rd_word;
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            wait_reg <= ETWB_WAIT_RST;
            md_reg <= etwb_md_t'(ETWB_MD_RST);
            bus8_reg <= 1'b0;
        end else if (wr_ok && sel_memctl && w_strb_reg[0]) begin
            wait_reg <= w_data_reg[ETWB_WAIT_LSB +: 2];
            md_reg <= etwb_md_t'(w_data_reg[ETWB_MD_LSB +: 2]);
            bus8_reg <= w_data_reg[ETWB_BUS8_BIT];
        end
    end

    // ------------------------------------------------------------
    // Bus input synchroniser: three stages, accept when 2 and 3 agree
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            ad_sync1_reg <= 16'h0000;
            ad_sync2_reg <= 16'h0000;
            ad_sync3_reg <= 16'h0000;
        end else begin
            ad_sync1_reg <= ad_i;
            ad_sync2_reg <= ad_sync1_reg;
            ad_sync3_reg <= ad_sync2_reg;
        end
    end
    wire ad_stable = (ad_sync2_reg == ad_sync3_reg);

    // ------------------------------------------------------------
    // Cycle start and data path; pointer, latch, holding latch
    // ------------------------------------------------------------
    assign ph.start = (cmd_wr || cmd_rd || cmd_fe) && !busy;
    assign ph.waits = waits_sel;

    wire [7:0] rd_byte = bus8_reg ? ad_sync3_reg[7:0]
        : (ptr0_reg ? ad_sync3_reg[15:8] : ad_sync3_reg[7:0]);

    wire word_even = (op_reg == ETWB_OP_WRITE) && !bus8_reg
        && (md_reg == ETWB_MD_WORD_WRITE) && !ptr0_reg;

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            op_reg <= ETWB_OP_NONE;
            ptr0_reg <= 1'b0;
            table_latch_reg <= 8'h00;
            table_pointer_reg <= ETWB_PTR_RST;
            hold_reg <= 8'h00;
            rword_reg <= 16'h0000;
        end else begin
            if (ph.start) begin
                op_reg <= cmd_wr ? ETWB_OP_WRITE : (cmd_rd ? ETWB_OP_READ : ETWB_OP_FETCH);
                ptr0_reg <= table_pointer_reg[0];
            end else if (ph.done) begin
                op_reg <= ETWB_OP_NONE;
            end
            if (wr_ok && sel_latch && w_strb_reg[0]) begin
                table_latch_reg <= w_data_reg[7:0];
            end else if (ph.done && op_reg == ETWB_OP_READ && ad_stable) begin
                table_latch_reg <= rd_byte;
            end
            if (ph.done && op_reg != ETWB_OP_WRITE && ad_stable) begin
                rword_reg <= ad_sync3_reg;
            end
            if (wr_ok && sel_ptr) begin
                table_pointer_reg <= w_data_reg[20:0];
            end
            if (ph.done && word_even) begin
                hold_reg <= table_latch_reg;
            end
        end
    end

    // ------------------------------------------------------------
    // Bus pin drive: address in first Tcy, data in the final one
    // ------------------------------------------------------------
    wire wr_data = (op_reg == ETWB_OP_WRITE) && ph.data_phase;
    wire addr_ph = ph.active && !ph.data_phase;

    wire [15:0] wr_word = (md_reg == ETWB_MD_WORD_WRITE)
        ? {table_latch_reg, hold_reg}
        : {table_latch_reg, table_latch_reg};
    wire drive_data = wr_data && !word_even;
    wire strobe_q = drive_data;

    wire use_hi = !bus8_reg && ((md_reg != ETWB_MD_BYTE_WRITE) || ptr0_reg);
    // Configuration space writes are not offered: no long-write command exists

    always_comb begin
        ad_o = 16'h0000;
        ad_oe_n_o = 16'hFFFF;
        if (addr_ph) begin
            ad_o = table_pointer_reg[15:0];
            ad_oe_n_o = 16'h0000;
        end else if (drive_data) begin
            ad_o = bus8_reg ? {8'h00, table_latch_reg} : wr_word;
            ad_oe_n_o = bus8_reg ? 16'hFF00 : 16'h0000;
        end
    end

    assign addr_o = table_pointer_reg;

    assign write_high_strobe_n_o = !(strobe_q && use_hi);
    assign write_low_strobe_n_o = !(strobe_q && !use_hi);
    assign read_strobe_n_o = !((op_reg == ETWB_OP_READ || op_reg == ETWB_OP_FETCH)
        && ph.data_phase);
    assign byte_address_line_o = ph.active ? ptr0_reg : table_pointer_reg[0];

    // Word mode odd selects both; byte select picks one; otherwise both
    wire sel_one = (md_reg == ETWB_MD_BYTE_SELECT) && !bus8_reg;
    assign upper_byte_select_n_o = !(ph.active && (!sel_one || ptr0_reg));
    assign lower_byte_select_n_o = !(ph.active && (!sel_one || !ptr0_reg));
    // Word-mode pairing is left to software
endmodule

/* File: etwb_core_assertions.sv */
// Concurrent checks on the external bus pins of the table write engine.
// Assumes it is bound to etwb_core and sees only that module's ports.
`timescale 1ns/1ns
module etwb_core_chk (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic srst_i,
    // Response channel
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    // External bus
    input wire logic [15:0] ad_o,
    input wire logic [15:0] ad_oe_n_o,
    input wire logic [20:0] addr_o,
    input wire logic write_high_strobe_n_o,
    input wire logic write_low_strobe_n_o,
    input wire logic byte_address_line_o,
    input wire logic read_strobe_n_o
);
    // ----------------------------------------
    // Strobe sequences and properties
    // ----------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (srst_i);
    sequence s_hi_hold;
        (!write_high_strobe_n_o)[*4];
    endsequence
    sequence s_lo_hold;
        (!write_low_strobe_n_o)[*4];
    endsequence
    sequence s_rd_hold;
        (!read_strobe_n_o)[*4];
    endsequence
    AST_ONE_STROBE: assert property (write_high_strobe_n_o || write_low_strobe_n_o)
        else $error("both write strobes low");
    AST_WHI_LEN: assert property ($fell(write_high_strobe_n_o) |->
        s_hi_hold ##[1:13] $rose(write_high_strobe_n_o)) else $error("high strobe length");
    AST_WLO_LEN: assert property ($fell(write_low_strobe_n_o) |->
        s_lo_hold ##[1:13] $rose(write_low_strobe_n_o)) else $error("low strobe length");
    AST_RD_LEN: assert property ($fell(read_strobe_n_o) |->
        s_rd_hold ##[1:13] $rose(read_strobe_n_o)) else $error("read strobe length");
    AST_BA_PTR: assert property (byte_address_line_o == addr_o[0])
        else $error("byte address differs from pointer");
    AST_LOW_DRIVEN: assert property (!(write_high_strobe_n_o && write_low_strobe_n_o)
        |-> ad_oe_n_o[7:0] == 8'h00) else $error("low byte floats during write");
    AST_DATA_STABLE: assert property (!write_high_strobe_n_o &&
        !$past(write_high_strobe_n_o) |-> $stable(ad_o)) else $error("data moved in strobe");
    AST_RD_NO_WR: assert property (!read_strobe_n_o |->
        write_high_strobe_n_o && write_low_strobe_n_o) else $error("write during read");
    AST_RD_FLOAT: assert property (!read_strobe_n_o |-> ad_oe_n_o == 16'hFFFF)
        else $error("bus driven during read");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
endmodule
bind etwb_core etwb_core_chk etwb_core_chk_i (.core_clk_i(core_clk_i), .srst_i(srst_i),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .ad_o(ad_o), .ad_oe_n_o(ad_oe_n_o), .addr_o(addr_o),
    .write_high_strobe_n_o(write_high_strobe_n_o),
    .write_low_strobe_n_o(write_low_strobe_n_o),
    .byte_address_line_o(byte_address_line_o), .read_strobe_n_o(read_strobe_n_o));

/* File: etwb_mem_model.sv */
// Behavioural word-wide memory on the external multiplexed bus.
// Assumes the bench resolves the shared bus and feeds it to ad_i.
`timescale 1ns/1ns
module etwb_mem_model (
    // Clock
    input wire logic clk_i,
    // Device bus
    input wire logic [15:0] ad_i,
    input wire logic whi_n_i,
    input wire logic wlo_n_i,
    input wire logic ubs_n_i,
    input wire logic lbs_n_i,
    input wire logic ba_i,
    input wire logic rd_n_i,
    // Read content and access delay
    input wire logic [15:0] rd_word_i,
    input wire logic [3:0] rd_dly_i,
    // Memory drive and write record
    output logic [15:0] mem_ad_o,
    output logic [31:0] wr_cnt_o,
    output logic [15:0] wr_data_o,
    output logic [4:0] wr_sig_o,
    output logic [7:0] wr_len_o,
    output logic [7:0] rd_len_o
);
    logic [7:0] wcnt = 8'h00;
    logic [7:0] rcnt = 8'h00;
    logic [7:0] cyc = 8'h00;
    initial wr_cnt_o = 32'h0;
    // Record each strobe, its selects and length
    always @(posedge clk_i) begin
        cyc <= cyc + 8'h01;
        if (!whi_n_i || !wlo_n_i) begin
            wcnt <= wcnt + 8'h01;
            wr_data_o <= ad_i;
            wr_sig_o <= {!whi_n_i, !wlo_n_i, !ubs_n_i, !lbs_n_i, ba_i};
        end else if (wcnt != 8'h00) begin
            wr_len_o <= wcnt;
            wr_cnt_o <= wr_cnt_o + 32'h1;
            wcnt <= 8'h00;
        end
        if (!rd_n_i) begin
            rcnt <= rcnt + 8'h01;
        end else if (rcnt != 8'h00) begin
            rd_len_o <= rcnt;
            rcnt <= 8'h00;
        end
    end
    // Valid only after the delay, otherwise a moving pattern
    assign mem_ad_o = (!rd_n_i && rcnt >= {4'h0, rd_dly_i}) ? rd_word_i : {cyc, ~cyc};
endmodule

/* File: etwb_core_test.sv */
// Self-checking bench for the table write engine over AXI4-Lite.
// Assumes the memory model on the far side and a 20 MHz clock.
`timescale 1ns/1ns
module etwb_core_test;
    import etwb_pkg::*;
    logic core_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0, r_r = 1'b0;
    logic [7:0] aw_a = 8'h00, ar_a = 8'h00, l;
    logic [31:0] w_d = 32'h0, r_d, d, wr_cnt, c0;
    logic aw_rdy, w_rdy, b_v, ar_rdy, r_v, whi_n, wlo_n, ubs_n, lbs_n, ba, rd_n;
    logic [1:0] b_resp, r_resp, r;
    logic [15:0] ad_o, ad_oe_n, ad_bus, mem_ad, wr_data, rd_word = 16'h0;
    logic [20:0] addr;
    logic [4:0] wr_sig;
    logic [7:0] wr_len, rd_len;
    logic [3:0] rd_dly = 4'h0;
    int error_cnt = 0, num_checks = 0, m, p;
    // Clock and shared bus
    always #25 core_clk_i = ~core_clk_i;
    assign ad_bus = (ad_o & ~ad_oe_n) | (mem_ad & ad_oe_n);
    etwb_core etwb_core_i (.core_clk_i(core_clk_i), .srst_i(srst_i), .s_axi_awaddr(aw_a),
        .s_axi_awvalid(aw_v), .s_axi_awready(aw_rdy), .s_axi_wdata(w_d), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(w_v), .s_axi_wready(w_rdy), .s_axi_bresp(b_resp), .s_axi_bvalid(b_v),
        .s_axi_bready(b_r), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v), .s_axi_arready(ar_rdy),
        .s_axi_rdata(r_d), .s_axi_rresp(r_resp), .s_axi_rvalid(r_v), .s_axi_rready(r_r),
        .ad_i(ad_bus), .ad_o(ad_o), .ad_oe_n_o(ad_oe_n), .addr_o(addr),
        .write_high_strobe_n_o(whi_n), .write_low_strobe_n_o(wlo_n),
        .upper_byte_select_n_o(ubs_n), .lower_byte_select_n_o(lbs_n),
        .byte_address_line_o(ba), .read_strobe_n_o(rd_n));
    etwb_mem_model etwb_mem_model_i (.clk_i(core_clk_i), .ad_i(ad_bus), .whi_n_i(whi_n),
        .wlo_n_i(wlo_n), .ubs_n_i(ubs_n), .lbs_n_i(lbs_n), .ba_i(ba), .rd_n_i(rd_n),
        .rd_word_i(rd_word), .rd_dly_i(rd_dly), .mem_ad_o(mem_ad), .wr_cnt_o(wr_cnt),
        .wr_data_o(wr_data), .wr_sig_o(wr_sig), .wr_len_o(wr_len), .rd_len_o(rd_len));
    // ----------------------------------------
    // Report, compare and bus tasks
    // ----------------------------------------
    task stop_test;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task tick(inout int n);
        @(posedge core_clk_i);
        n++;
        if (n > 400) begin
            error_cnt++;
            stop_test();
        end
    endtask
    task axi_wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
        int n;
        logic ap, wp;
        n = 0;
        ap = 1'b1;
        wp = 1'b1;
        aw_a <= a;
        w_d <= v;
        aw_v <= 1'b1;
        w_v <= 1'b1;
        b_r <= 1'b1;
        while (ap || wp) begin
            tick(n);
            if (ap && aw_rdy) begin
                ap = 1'b0;
                aw_v <= 1'b0;
            end
            if (wp && w_rdy) begin
                wp = 1'b0;
                w_v <= 1'b0;
            end
        end
        do tick(n); while (b_v !== 1'b1);
        b_r <= 1'b0;
        check("bresp", b_resp, er);
        @(posedge core_clk_i);
    endtask
    task axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        int n;
        n = 0;
        ar_a <= a;
        ar_v <= 1'b1;
        r_r <= 1'b1;
        do tick(n); while (ar_rdy !== 1'b1);
        ar_v <= 1'b0;
        do tick(n); while (r_v !== 1'b1);
        v = r_d;
        rs = r_resp;
        r_r <= 1'b0;
        @(posedge core_clk_i);
    endtask
    task rd_chk(input logic [7:0] a, input logic [31:0] exp, input string name);
        axi_rd(a, d, r);
        check(name, d, exp);
    endtask
    task idle;
        int k;
        k = 0;
        do begin
            axi_rd(ETWB_CMD_OFF, d, r);
            k++;
        end while (d[ETWB_BUSY_BIT] !== 1'b0 && k < 40);
        if (d[ETWB_BUSY_BIT] !== 1'b0) begin
            error_cnt++;
            stop_test();
        end
    endtask
    task op(input logic [31:0] ptr, input logic [31:0] lat, input logic [31:0] cmd);
        axi_wr(ETWB_PTR_OFF, ptr, 2'b00);
        axi_wr(ETWB_LATCH_OFF, lat, 2'b00);
        axi_wr(ETWB_CMD_OFF, cmd, 2'b00);
        idle();
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (5) @(posedge core_clk_i);
        srst_i <= 1'b0;
        @(posedge core_clk_i);
        rd_chk(ETWB_MEMCTL_OFF, 32'h3, "memctl_reset");
        axi_rd(8'h14, d, r);
        check("rresp_unmapped", r, 2'b10);
        axi_wr(8'h14, 32'h0, 2'b10);
        // Byte write then byte select with three waits
        for (m = 0; m < 2; m++) begin
            axi_wr(ETWB_MEMCTL_OFF, m ? 32'h23 : 32'h00, 2'b00);
            for (p = 0; p < 2; p++) begin
                l = 8'h5A ^ 8'(p + 2 * m);
                op(32'h1234A | p, {24'h0, l}, 32'h1);
                check("wr_data", wr_data, {l, l});
                check("wr_sig", wr_sig & (m ? 5'h1F : 5'h18),
                    m ? (p ? 5'h15 : 5'h12) : (p ? 5'h10 : 5'h08));
                check("wr_len", wr_len, m ? 16 : 4);
            end
        end
        // Word mode, even then odd on one word
        axi_wr(ETWB_MEMCTL_OFF, 32'h10, 2'b00);
        c0 = wr_cnt;
        op(32'h100, 32'hA5, 32'h1);
        check("even_cnt", wr_cnt, c0);
        op(32'h101, 32'h3C, 32'h1);
        check("odd_data", wr_data, 16'h3CA5);
        check("odd_sig", wr_sig, 5'h17);
        // Eight-bit bus
        axi_wr(ETWB_MEMCTL_OFF, 32'h80, 2'b00);
        op(32'h7, 32'h96, 32'h1);
        check("b8_sig", wr_sig[4:3], 2'b01);
        check("b8_data", wr_data[7:0], 8'h96);
        // Slow memory reads with three waits, then a fetch
        axi_wr(ETWB_MEMCTL_OFF, 32'h03, 2'b00);
        rd_word <= 16'hC3E1;
        rd_dly <= 4'h8;
        for (p = 0; p < 2; p++) begin
            op(32'h40 | p, 32'h0, 32'h2);
            rd_chk(ETWB_LATCH_OFF, p ? 32'hC3 : 32'hE1, "rd_byte");
            check("rd_len", rd_len, 16);
        end
        rd_chk(ETWB_RDATA_OFF, 32'hC3E1, "rd_word");
        op(32'h40, 32'h0, 32'h4);
        check("fetch_len", rd_len, 4);
        // Latch write refused while a write runs
        axi_wr(ETWB_CMD_OFF, 32'h1, 2'b00);
        axi_wr(ETWB_LATCH_OFF, 32'h77, 2'b10);
        rd_chk(ETWB_LATCH_OFF, 32'h0, "latch_kept");
        idle();
        stop_test();
    end
endmodule
